// *** rtl/sbio_pkg.sv ***
// shared constants, types and register map of the servo brake and io status block
package sbio_pkg;

    // ------------------------------------------------------------
    // parameter addresses
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_COMBINED  = 16'h0802;
    localparam logic [15:0] ADDR_INPUTS    = 16'h081e;
    localparam logic [15:0] ADDR_OUTPUTS   = 16'h0820;
    localparam logic [15:0] ADDR_TORQUEOFF = 16'h084c;
    localparam logic [15:0] ADDR_BRAKEMODE = 16'h0814;
    localparam logic [15:0] ADDR_VCEILING  = 16'h1120;

    // ------------------------------------------------------------
    // values, limits and field positions
    // ------------------------------------------------------------
    localparam logic [31:0] VCEIL_RESET    = 32'h0000_3390;
    localparam logic [31:0] VCEIL_MIN      = 32'h0000_0001;
    localparam logic [31:0] VCEIL_MAX      = 32'h7fff_ffff;
    localparam logic [15:0] ERR_TORQUE_OFF = 16'h0514;   // 1300 decimal
    localparam logic [15:0] ERR_NONE       = 16'h0000;
    localparam int          COMB_OUT_LSB   = 8;
    localparam logic [3:0]  OPST_SWON_DIS  = 4'h3;
    localparam logic [3:0]  OPST_READY     = 4'h4;
    localparam logic [3:0]  OPST_OP_EN     = 4'h6;
    localparam logic [3:0]  OPST_FAULT     = 4'h9;

    // ------------------------------------------------------------
    // timing: nameplate delays are in ms, clock is 10 MHz
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_IN_NS      = 1000000;
    localparam int CYC_PER_MS    = MS_IN_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BRK_AUTO    = 2'h0,
        BRAKE_MODE_SELECTOR = 2'h1,
        BRK_APPLY   = 2'h2
    } sbio_brk_mode_t;

    typedef enum logic [3:0] {
        ST_HELD      = 4'h1,
        ST_RELEASING = 4'h2,
        ST_RUN       = 4'h4,
        ST_APPLYING  = 4'h8
    } sbio_state_t;

    typedef struct packed {
        logic [3:0] in;
        logic [1:0] out;
        logic       torque_off_channel_a;
        logic       torque_off_channel_b;
    } sbio_pins_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [15:0] addr;
        logic [31:0] wdata;
    } sbio_par_req_t;

endpackage

// *** rtl/sbio_top.sv ***
// servo brake sequencer, speed clamp and pin status words
module sbio_top #(
    parameter int CYC_PER_MS = sbio_pkg::CYC_PER_MS
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    nrst,
    // fieldbus parameter access
    input  wire sbio_pkg::sbio_par_req_t par,
    output logic                         par_ack,
    output logic                         par_err,
    output logic [31:0]                  par_rdata,
    // pins and motor feedback
    input  wire sbio_pkg::sbio_pins_t    pins,
    input  wire logic                    limit_pos,
    input  wire logic                    limit_neg,
    input  wire logic                    standstill,
    input  wire logic                    fault_reset,
    // drive state and nameplate
    input  wire logic                    power_stage_req,
    input  wire logic [3:0]              op_state,
    input  wire logic [15:0]             release_delay_ms,
    input  wire logic [15:0]             apply_delay_ms,
    input  wire logic [31:0]             motor_max_speed,
    input  wire logic                    input_vlim_act,
    input  wire logic [31:0]             input_vlim,
    input  wire logic [31:0]             speed_cmd,
    // results
    output logic [31:0]                  speed_out,
    output logic                         motor_current,
    output logic                         brake_release,
    output logic                         op_enable_ok,
    output logic                         limit_error,
    output logic [15:0]                  error_code
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] min2(input logic [31:0] a, input logic [31:0] b);
        return (a < b) ? a : b;
    endfunction

    function automatic logic [31:0] ms_cycles(input logic [15:0] ms);
        return 32'(ms) * 32'(CYC_PER_MS);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [31:0]              vceil_q;
    sbio_pkg::sbio_brk_mode_t mode_q;
    sbio_pkg::sbio_state_t    st_q, st_d;
    logic [31:0]              cnt_q, cnt_d;
    logic [15:0]              comb_q, in_q, out_q, sto_q;
    logic                     sto_err_q, lim_err_q;
    logic [31:0]              speed_q;

    // ------------------------------------------------------------
    // parameter decode
    // ------------------------------------------------------------
    wire hit_comb = par.addr == sbio_pkg::ADDR_COMBINED;
    wire hit_in   = par.addr == sbio_pkg::ADDR_INPUTS;
    wire hit_out  = par.addr == sbio_pkg::ADDR_OUTPUTS;
    wire hit_sto  = par.addr == sbio_pkg::ADDR_TORQUEOFF;
    wire hit_mode = par.addr == sbio_pkg::ADDR_BRAKEMODE;
    wire hit_vcl  = par.addr == sbio_pkg::ADDR_VCEILING;
    wire hit_any  = hit_comb | hit_in | hit_out | hit_sto | hit_mode | hit_vcl;
    wire wr       = par.req & par.we;

    // ceiling range is checked so a zero ceiling can never stall the axis
    wire vcl_ok   = par.wdata >= sbio_pkg::VCEIL_MIN && par.wdata <= sbio_pkg::VCEIL_MAX;
    wire wr_vcl   = wr & hit_vcl & vcl_ok;
    // apply needs standstill; release from apply must pass through auto
    wire mode_ok  = (par.wdata == 32'(sbio_pkg::BRK_AUTO))
                  | (par.wdata == 32'(sbio_pkg::BRAKE_MODE_SELECTOR) && mode_q != sbio_pkg::BRK_APPLY)
                  | (par.wdata == 32'(sbio_pkg::BRK_APPLY) && standstill);
    wire wr_mode  = wr & hit_mode & mode_ok;
    wire bad      = par.req & (~hit_any | (par.we & ~(wr_vcl | wr_mode)));

    // read data selection
    wire [31:0] rd_sel = hit_comb ? 32'(comb_q) :
                         hit_in   ? 32'(in_q)   :
                         hit_out  ? 32'(out_q)  :
                         hit_sto  ? 32'(sto_q)  :
                         hit_mode ? 32'(mode_q) :
                         hit_vcl  ? vceil_q     : 32'h0000_0000;

    // ------------------------------------------------------------
    // parameter registers and bus answer, one cycle after request
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            vceil_q   <= sbio_pkg::VCEIL_RESET;
            mode_q    <= sbio_pkg::BRK_AUTO;
            par_ack   <= 1'b0;
            par_err   <= 1'b0;
            par_rdata <= 32'h0000_0000;
        end else begin
            if (wr_vcl) vceil_q <= par.wdata;
            if (wr_mode) mode_q <= sbio_pkg::sbio_brk_mode_t'(par.wdata[1:0]);
            par_ack   <= par.req;
            par_err   <= bad;
            par_rdata <= (par.req && !par.we && hit_any) ? rd_sel : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // pin status words, sampled every cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            comb_q <= 16'h0000;
            in_q   <= 16'h0000;
            out_q  <= 16'h0000;
            sto_q  <= 16'h0000;
        end else begin
            comb_q <= 16'({pins.out, 4'h0, pins.in});
            in_q   <= 16'(pins.in);
            out_q  <= 16'(pins.out);
            sto_q  <= 16'({pins.torque_off_channel_b, pins.torque_off_channel_a});
        end
    end

    // ------------------------------------------------------------
    // speed clamp: any change of a ceiling acts on the next cycle
    // ------------------------------------------------------------
    wire [31:0] vlim_mv = min2(vceil_q, motor_max_speed);
    wire [31:0] vlim    = input_vlim_act ? min2(vlim_mv, input_vlim) : vlim_mv;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) speed_q <= 32'h0000_0000;
        else       speed_q <= min2(speed_cmd, vlim);
    end
    assign speed_out = speed_q;

    // ------------------------------------------------------------
    // error flags; a new event wins over a reset in the same cycle
    // ------------------------------------------------------------
    // torque-off inputs are active low: either channel low trips
    wire sto_trip = ~(pins.torque_off_channel_a & pins.torque_off_channel_b);
    wire sto_hit  = sto_trip & (st_q != sbio_pkg::ST_HELD);
    wire lim_hit  = limit_pos | limit_neg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sto_err_q <= 1'b0;
            lim_err_q <= 1'b0;
        end else begin
            sto_err_q <= sto_hit | (sto_err_q & ~fault_reset);
            lim_err_q <= lim_hit | (lim_err_q & ~fault_reset);
        end
    end
    assign limit_error = lim_err_q;
    assign error_code  = sto_err_q ? sbio_pkg::ERR_TORQUE_OFF : sbio_pkg::ERR_NONE;

    // ------------------------------------------------------------
    // brake sequencer
    // ------------------------------------------------------------
    // a stored torque-off error keeps the stage off until fault reset
    wire pwr_en   = power_stage_req & ~sto_trip & ~sto_err_q;
    wire cnt_done = cnt_q == 32'h0000_0000;

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_done ? cnt_q : cnt_q - 32'h0000_0001;
        unique case (st_q)
            sbio_pkg::ST_HELD: begin
                if (pwr_en) begin
                    st_d  = sbio_pkg::ST_RELEASING;
                    cnt_d = ms_cycles(release_delay_ms);
                end
            end
            sbio_pkg::ST_RELEASING: begin
                if (sto_trip) begin
                    st_d = sbio_pkg::ST_HELD;
                end else if (!pwr_en) begin
                    st_d  = sbio_pkg::ST_APPLYING;
                    cnt_d = ms_cycles(apply_delay_ms);
                end else if (cnt_done) begin
                    st_d = sbio_pkg::ST_RUN;
                end
            end
            sbio_pkg::ST_RUN: begin
                if (sto_trip) begin
                    st_d = sbio_pkg::ST_HELD;
                end else if (!pwr_en) begin
                    st_d  = sbio_pkg::ST_APPLYING;
                    cnt_d = ms_cycles(apply_delay_ms);
                end
            end
            sbio_pkg::ST_APPLYING: begin
                if (sto_trip || cnt_done) st_d = sbio_pkg::ST_HELD;
            end
            default: begin
                st_d = sbio_pkg::ST_HELD;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q  <= sbio_pkg::ST_HELD;
            cnt_q <= 32'h0000_0000;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
        end
    end

    // ------------------------------------------------------------
    // outputs of the sequencer
    // ------------------------------------------------------------
    wire man_apply = mode_q == sbio_pkg::BRK_APPLY;
    wire man_rel   = mode_q == sbio_pkg::BRAKE_MODE_SELECTOR
                   && (op_state == sbio_pkg::OPST_SWON_DIS
                    || op_state == sbio_pkg::OPST_READY
                    || op_state == sbio_pkg::OPST_FAULT);
    wire energised = st_q == sbio_pkg::ST_RELEASING || st_q == sbio_pkg::ST_RUN;

    assign motor_current = (st_q != sbio_pkg::ST_HELD) & ~sto_trip;
    // manual apply overrides automatic and manual release alike
    assign brake_release = ~man_apply & ((energised & ~sto_trip) | man_rel);
    assign op_enable_ok  = st_q == sbio_pkg::ST_RUN;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    ceil_write_a: assert property (@(posedge clk) disable iff (!nrst)
        wr_vcl |=> vceil_q == $past(par.wdata))
        else $error("ceiling write not taken at once");

    speed_clamp_a: assert property (@(posedge clk) disable iff (!nrst)
        1'b1 |=> speed_out <= $past(vceil_q) && speed_out <= $past(motor_max_speed))
        else $error("speed exceeds a ceiling");

    comb_read_a: assert property (@(posedge clk) disable iff (!nrst)
        par.req && !par.we && hit_comb ##1 1'b1 |-> par_rdata[9:8] == $past(out_q[1:0], 1))
        else $error("combined word outputs misplaced");

    sto_trip_a: assert property (@(posedge clk) disable iff (!nrst)
        sto_hit |-> !motor_current ##1 error_code == sbio_pkg::ERR_TORQUE_OFF)
        else $error("torque-off did not disable and report");

    run_delay_a: assert property (@(posedge clk) disable iff (!nrst)
        $rose(op_enable_ok) |-> $past(cnt_q) == 32'h0000_0000
                                && $past(st_q) == sbio_pkg::ST_RELEASING)
        else $error("operation enabled before release delay");

    apply_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        st_q == sbio_pkg::ST_APPLYING && !sto_trip |-> motor_current && !brake_release)
        else $error("current dropped during apply delay");

    manual_apply_a: assert property (@(posedge clk) disable iff (!nrst)
        man_apply |-> !brake_release)
        else $error("brake released under manual apply");

    release_state_a: assert property (@(posedge clk) disable iff (!nrst)
        st_q == sbio_pkg::ST_HELD && op_state == sbio_pkg::OPST_OP_EN |-> !brake_release)
        else $error("manual release in forbidden state");

    // a fault reset may follow the switch at once, so only the next cycle is owed
    limit_flag_a: assert property (@(posedge clk) disable iff (!nrst)
        lim_hit |=> limit_error)
        else $error("limit switch not reported");

    limit_sticky_a: assert property (@(posedge clk) disable iff (!nrst)
        limit_error && !fault_reset |=> limit_error)
        else $error("limit error lost without fault reset");

    apply_standstill_a: assert property (@(posedge clk) disable iff (!nrst)
        wr && hit_mode && par.wdata == 32'(sbio_pkg::BRK_APPLY) && !standstill
        |=> par_err && !man_apply)
        else $error("manual apply accepted while moving");

    // sequencer invariants: a held stage never carries current
    held_no_current_a: assert property (@(posedge clk) disable iff (!nrst)
        st_q == sbio_pkg::ST_HELD |-> !motor_current && !op_enable_ok)
        else $error("current flows with brake held");

    held_brake_a: assert property (@(posedge clk) disable iff (!nrst)
        st_q == sbio_pkg::ST_HELD && !man_rel |-> !brake_release)
        else $error("brake open in held state");

    auto_release_a: assert property (@(posedge clk) disable iff (!nrst)
        energised && !sto_trip && !man_apply |-> brake_release)
        else $error("brake not released with stage on");

    release_timer_a: assert property (@(posedge clk) disable iff (!nrst)
        st_q == sbio_pkg::ST_HELD && pwr_en
        |=> st_q == sbio_pkg::ST_RELEASING && cnt_q == ms_cycles($past(release_delay_ms)))
        else $error("release delay not loaded");

    apply_timer_a: assert property (@(posedge clk) disable iff (!nrst)
        st_q == sbio_pkg::ST_RUN && !pwr_en && !sto_trip
        |=> st_q == sbio_pkg::ST_APPLYING && cnt_q == ms_cycles($past(apply_delay_ms)))
        else $error("apply delay not loaded");

    mode_write_a: assert property (@(posedge clk) disable iff (!nrst)
        wr_mode |=> mode_q == $past(par.wdata[1:0]))
        else $error("brake mode write not taken");

    status_word_a: assert property (@(posedge clk) disable iff (!nrst)
        1'b1 |=> in_q == 16'($past(pins.in))
                 && sto_q == 16'({$past(pins.torque_off_channel_b), $past(pins.torque_off_channel_a)}))
        else $error("pin status words stale");

    stage_off_a: assert property (@(posedge clk) disable iff (!nrst)
        sto_err_q |-> !motor_current && !op_enable_ok)
        else $error("stage on with torque-off error stored");

endmodule // sbio_top

// *** verification/sbio_motor_model.sv ***
// behavioural motor and holding brake on the far side of the block
module sbio_motor_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // drive outputs to the motor
    input  wire logic motor_current,
    input  wire logic brake_release,
    // feedback to the drive
    output logic      standstill
);
    timeunit 1ns;
    timeprecision 1ns;

    // shaft turns only with current on and brake open; one cycle of inertia
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            standstill <= 1'b1;
        end else begin
            standstill <= !(motor_current && brake_release);
        end
    end
endmodule // sbio_motor_model

// *** verification/sbio_tb.sv ***
// self-checking bench: parameter accesses, pin words, speed clamp, brake sequence
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic                   clk, nrst, par_ack, par_err, limit_pos, limit_neg, standstill;
    logic                   fault_reset, power_stage_req, input_vlim_act;
    logic                   motor_current, brake_release, op_enable_ok, limit_error;
    logic [3:0]             op_state;
    logic [15:0]            release_delay_ms, apply_delay_ms, error_code;
    logic [31:0]            par_rdata, motor_max_speed, input_vlim, speed_cmd, speed_out;
    sbio_pkg::sbio_par_req_t par;
    sbio_pkg::sbio_pins_t   pins;
    int                     errors, compares, cyc;

    sbio_top #(.CYC_PER_MS(2)) DUT (
        .clk(clk), .nrst(nrst), .par(par), .par_ack(par_ack), .par_err(par_err),
        .par_rdata(par_rdata), .pins(pins), .limit_pos(limit_pos), .limit_neg(limit_neg),
        .standstill(standstill), .fault_reset(fault_reset),
        .power_stage_req(power_stage_req), .op_state(op_state),
        .release_delay_ms(release_delay_ms), .apply_delay_ms(apply_delay_ms),
        .motor_max_speed(motor_max_speed), .input_vlim_act(input_vlim_act),
        .input_vlim(input_vlim), .speed_cmd(speed_cmd), .speed_out(speed_out),
        .motor_current(motor_current), .brake_release(brake_release),
        .op_enable_ok(op_enable_ok), .limit_error(limit_error), .error_code(error_code));

    sbio_motor_model MOTOR (
        .clk(clk), .nrst(nrst), .motor_current(motor_current),
        .brake_release(brake_release), .standstill(standstill));

    // ------------------------------------------------------------
    // clock, timeout and helpers
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            errors = errors + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // inputs always move 10 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask

    // one access: request for one cycle, answer checked in the following cycle
    task automatic acc(input logic we, input logic [15:0] a, input logic [31:0] d,
                       input logic ee, input logic [31:0] er);
        par = '{1'b1, we, a, d};
        tick(1);
        par.req = 1'b0;
        chk({31'h0, par_ack}, 32'h1);
        chk({31'h0, par_err}, {31'h0, ee});
        if (!we && !ee) begin
            chk(par_rdata, er);
        end
        tick(1);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        errors = 0;
        compares = 0;
        cyc = 0;
        nrst = 1'b0;
        par = '0;
        pins = '{4'h0, 2'h0, 1'b1, 1'b1};
        {limit_pos, limit_neg, fault_reset, power_stage_req, input_vlim_act} = 5'h00;
        op_state = 4'h3;
        release_delay_ms = 16'h0003;
        apply_delay_ms = 16'h0002;
        motor_max_speed = 32'h0000_7530;
        input_vlim = 32'h0000_01f4;
        speed_cmd = 32'h0000_4e20;
        tick(3);
        nrst = 1'b1;
        tick(1);
        // defaults, unmapped place and refused writes
        acc(1'b0, 16'h1120, 32'h0, 1'b0, 32'h0000_3390);
        acc(1'b0, 16'h0814, 32'h0, 1'b0, 32'h0000_0000);
        acc(1'b0, 16'h0900, 32'h0, 1'b1, 32'h0);
        acc(1'b1, 16'h0802, 32'h0, 1'b1, 32'h0);
        acc(1'b1, 16'h1120, 32'h0, 1'b1, 32'h0);
        acc(1'b1, 16'h1120, 32'h8000_0000, 1'b1, 32'h0);
        acc(1'b1, 16'h0814, 32'h3, 1'b1, 32'h0);
        // pin words with two complementary patterns
        for (int i = 0; i < 2; i++) begin
            if (i == 0) pins = '{4'ha, 2'h2, 1'b1, 1'b0};
            else        pins = '{4'h5, 2'h1, 1'b0, 1'b1};
            tick(2);
            acc(1'b0, 16'h0802, 32'h0, 1'b0, {22'h0, pins.out, 4'h0, pins.in});
            acc(1'b0, 16'h081e, 32'h0, 1'b0, {28'h0, pins.in});
            acc(1'b0, 16'h0820, 32'h0, 1'b0, {30'h0, pins.out});
            acc(1'b0, 16'h084c, 32'h0, 1'b0, {30'h0, pins.torque_off_channel_b, pins.torque_off_channel_a});
        end
        pins = '{4'h0, 2'h0, 1'b1, 1'b1};
        // speed clamp takes the smallest active ceiling
        tick(2);
        chk(speed_out, 32'h0000_3390);
        input_vlim_act = 1'b1;
        tick(2);
        chk(speed_out, 32'h0000_01f4);
        motor_max_speed = 32'h0000_0064;
        tick(2);
        chk(speed_out, 32'h0000_0064);
        acc(1'b1, 16'h1120, 32'h0000_0032, 1'b0, 32'h0);
        chk(speed_out, 32'h0000_0032);
        acc(1'b1, 16'h1120, 32'h7fff_ffff, 1'b0, 32'h0);
        // limit switch error is sticky until fault reset
        limit_neg = 1'b1;
        tick(2);
        limit_neg = 1'b0;
        tick(2);
        chk({31'h0, limit_error}, 32'h1);
        fault_reset = 1'b1;
        tick(2);
        // switch event while fault reset is held: the event must win
        limit_pos = 1'b1;
        tick(2);
        chk({31'h0, limit_error}, 32'h1);
        limit_pos = 1'b0;
        fault_reset = 1'b1;
        tick(2);
        fault_reset = 1'b0;
        chk({31'h0, limit_error}, 32'h0);
        // automatic release, timed enable, refused apply while turning, timed apply
        power_stage_req = 1'b1;
        tick(1);
        chk({30'h0, motor_current, brake_release}, 32'h3);
        chk({31'h0, op_enable_ok}, 32'h0);
        tick(5);
        chk({31'h0, op_enable_ok}, 32'h0);
        tick(4);
        chk({31'h0, op_enable_ok}, 32'h1);
        acc(1'b1, 16'h0814, 32'h2, 1'b1, 32'h0);
        power_stage_req = 1'b0;
        tick(1);
        chk({30'h0, motor_current, brake_release}, 32'h2);
        tick(2);
        chk({31'h0, motor_current}, 32'h1);
        tick(6);
        chk({31'h0, motor_current}, 32'h0);
        // torque off during the release delay drops the stage and stores the code
        power_stage_req = 1'b1;
        tick(3);
        pins.torque_off_channel_a = 1'b0;
        tick(1);
        chk({31'h0, motor_current}, 32'h0);
        chk({16'h0, error_code}, 32'h0000_0514);
        pins.torque_off_channel_a = 1'b1;
        power_stage_req = 1'b0;
        tick(2);
        fault_reset = 1'b1;
        tick(2);
        fault_reset = 1'b0;
        chk({16'h0, error_code}, 32'h0);
        // manual apply at standstill holds against enable and manual release
        acc(1'b1, 16'h0814, 32'h2, 1'b0, 32'h0);
        acc(1'b0, 16'h0814, 32'h0, 1'b0, 32'h0000_0002);
        power_stage_req = 1'b1;
        tick(3);
        chk({30'h0, motor_current, brake_release}, 32'h2);
        acc(1'b1, 16'h0814, 32'h1, 1'b1, 32'h0);
        power_stage_req = 1'b0;
        tick(8);
        acc(1'b1, 16'h0814, 32'h0, 1'b0, 32'h0);
        acc(1'b1, 16'h0814, 32'h1, 1'b0, 32'h0);
        // manual release only in the listed states
        for (int s = 0; s < 4; s++) begin
            op_state = (s == 0) ? 4'h3 : (s == 1) ? 4'h4 : (s == 2) ? 4'h9 : 4'h6;
            tick(1);
            chk({31'h0, brake_release}, {31'h0, s != 3});
        end
        acc(1'b1, 16'h0814, 32'h0, 1'b0, 32'h0);
        tick(2);
        end_of_test();
    end
endmodule // tb
